// *** rtc_core.sv ***
// Contactless front-end register slice: status, transmit CRC appender
// and transmitter 1 reader-mode wave settings.
// Assumes sequencer and decoder status arrive from logic on core_clk_in.
// Operation
// - The 3-bit sequencer state reads 0 idle up to 6 echo, 7 reserved.
// - Bit 5 reads 1 once the receive decoder is enabled and ready.
// - Bit 4 reads 1 while the transmit encoder sends a frame.
// - Bit 3 reads 1 while the receive decoder receives a frame.
// - The field cause code reports codes 1 to 4, 5 to 7 reserved.
// - Preset selector codes 0 to 5 load their fixed preset values.
// - Selector code 7 loads the software preset from the upper half.
// - With the 5-bit type only the low byte of the preset is used.
// - Bit 2 picks a 16-bit CRC at 0 and a 5-bit CRC at 1.
// - Bit 1 sends the checksum inverted when set.
// - Bit 0 enables computing and appending the CRC to the frame.
// - Bit 6 leaves the first frame byte out of the CRC.
// - An 8-bit field sets the modulated wave amplitude.
// - An 8-bit field sets the carrier amplitude, reset to full.
// - Three 3-bit fields pick the clock mode for edge, modulated, carrier.
//
// The strobed register port is this design's own decision.

`timescale 1ns/10ps
`default_nettype none

module rtc_core (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // Register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // Sequencer and decoder status
  input wire logic [2:0] seq_state_in,
  input wire logic rx_enable_in,
  input wire logic rx_active_in,
  input wire logic [2:0] field_cause_in,
  // Frame bytes from the send buffer
  input wire logic in_valid_in,
  input wire logic [7:0] in_data_in,
  input wire logic in_last_in,
  output logic in_ready_out,
  // Bytes to the transmit encoder
  output logic out_valid_out,
  output logic [7:0] out_data_out,
  output logic out_last_out,
  input wire logic out_ready_in,
  output logic tx_active_out,
  // Transmitter 1 reader-mode settings
  output logic [7:0] drv1_level_carrier_out,
  output logic [7:0] drv1_level_modulated_out,
  output logic [2:0] drv1_clkmode_carrier_out,
  output logic [2:0] drv1_clkmode_modulated_out,
  output logic [2:0] drv1_clkmode_edge_out
);

  typedef enum logic [3:0] {
    RTC_IDLE = 4'h1,
    RTC_DATA = 4'h2,
    RTC_CRC_LO = 4'h4,
    RTC_CRC_HI = 4'h8
  } rtc_state_e;

  rtc_state_e state;
  rtc_state_e next_state;
  logic [31:0] tx_crc_config;
  logic [31:0] tx1_reader_wave_config;
  logic [15:0] crc;
  logic [15:0] next_crc;

  // Configuration fields
  wire crc_enable = tx_crc_config[rtc_pkg::CC_ENABLE];
  wire crc_invert_out = tx_crc_config[rtc_pkg::CC_INVERT];
  wire crc_five = tx_crc_config[rtc_pkg::CC_TYPE5];
  wire crc_skip_first_byte = tx_crc_config[rtc_pkg::CC_SKIP];
  wire [2:0] preset_sel = tx_crc_config[rtc_pkg::CC_SEL_LSB +: 3];
  wire [15:0] preset_custom = tx_crc_config[rtc_pkg::CC_PRESET_LSB +: 16];

  // Register decode
  wire hit_status = addr_in == rtc_pkg::ADDR_STATUS;
  wire hit_crc_cfg = addr_in == rtc_pkg::ADDR_CRC_CFG;
  wire hit_wave_cfg = addr_in == rtc_pkg::ADDR_WAVE_CFG;
  wire wr_crc_cfg = wr_in && hit_crc_cfg;
  wire wr_wave_cfg = wr_in && hit_wave_cfg;

  // Software-written registers, reserved bits held at zero
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tx_crc_config <= rtc_pkg::CRC_CFG_RESET;
      tx1_reader_wave_config <= rtc_pkg::WAVE_CFG_RESET;
    end else begin
      if (wr_crc_cfg) begin
        tx_crc_config <= wdata_in & rtc_pkg::CRC_CFG_MASK;
      end
      if (wr_wave_cfg) begin
        tx1_reader_wave_config <= wdata_in & rtc_pkg::WAVE_CFG_MASK;
      end
    end
  end

  // Transmitter settings straight from the register flops
  assign drv1_level_carrier_out =
    tx1_reader_wave_config[rtc_pkg::WV_CARRIER_LSB +: 8];
  assign drv1_level_modulated_out =
    tx1_reader_wave_config[rtc_pkg::WV_MOD_LSB +: 8];
  assign drv1_clkmode_carrier_out =
    tx1_reader_wave_config[rtc_pkg::WV_CLK_CW_LSB +: 3];
  assign drv1_clkmode_modulated_out =
    tx1_reader_wave_config[rtc_pkg::WV_CLK_MOD_LSB +: 3];
  assign drv1_clkmode_edge_out =
    tx1_reader_wave_config[rtc_pkg::WV_CLK_EDGE_LSB +: 3];

  // Status word; inputs are same-clock logic, so no synchroniser
  wire [31:0] status_word = {21'h0,
    field_cause_in,
    2'h0,
    rx_enable_in,
    tx_active_out,
    rx_active_in,
    seq_state_in};

  // Read mux, unmapped offsets answer zero
  wire [31:0] read_mux =
    hit_status ? status_word :
    hit_crc_cfg ? tx_crc_config :
    hit_wave_cfg ? tx1_reader_wave_config : 32'h0;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_out <= 32'h0;
    end else begin
      rdata_out <= rd_in ? read_mux : 32'h0;
    end
  end

  // Preset selection; the reserved code falls back to zero
  wire [15:0] preset_full =
    (preset_sel == rtc_pkg::SEL_CUSTOM) ? preset_custom :
    (preset_sel == 3'h1) ? rtc_pkg::PRESET_1 :
    (preset_sel == 3'h2) ? rtc_pkg::PRESET_2 :
    (preset_sel == 3'h3) ? rtc_pkg::PRESET_3 :
    (preset_sel == 3'h4) ? rtc_pkg::PRESET_4 :
    (preset_sel == 3'h5) ? rtc_pkg::PRESET_5 : rtc_pkg::PRESET_0;
  wire [15:0] init_val = crc_five ? {8'h00, preset_full[7:0]} : preset_full;

  // Two-entry buffer toward the encoder
  logic [8:0] buf_mem [0:1];
  logic buf_wr_ptr;
  logic buf_rd_ptr;
  logic [1:0] buf_count;
  wire buf_ready = buf_count != rtc_pkg::BUF_DEPTH;
  wire buf_pop = out_valid_out && out_ready_in;

  // Handshakes and state decode
  wire st_idle = state == RTC_IDLE;
  wire st_data = state == RTC_DATA;
  wire st_lo = state == RTC_CRC_LO;
  wire st_hi = state == RTC_CRC_HI;
  assign in_ready_out = buf_ready && (st_idle || st_data);
  wire take = in_valid_in && in_ready_out;
  wire push = take || (buf_ready && (st_lo || st_hi));
  wire tail_lo = st_lo && buf_ready;

  // Checksum bytes, inverted on request
  wire [7:0] inv_mask = {8{crc_invert_out}};
  wire [7:0] crc_lo_byte = crc_five ? {3'h0, crc[4:0] ^ inv_mask[4:0]}
                                    : crc[7:0] ^ inv_mask;
  wire [7:0] crc_hi_byte = crc[15:8] ^ inv_mask;
  wire [7:0] push_data = st_lo ? crc_lo_byte :
                         st_hi ? crc_hi_byte : in_data_in;
  wire push_last = st_hi || (st_lo && crc_five) ||
                   (in_last_in && !crc_enable);

  // CRC byte engine, started from the preset on the first byte
  logic [15:0] crc_step;
  rtc_crc_byte u_crc (
    .crc_in(st_idle ? init_val : crc),
    .data_in(in_data_in),
    .five_in(crc_five),
    .crc_out(crc_step)
  );

  // Next CRC value and frame sequence
  always_comb begin
    next_state = state;
    next_crc = crc;
    unique case (state)
      RTC_IDLE: begin
        next_crc = init_val;
        if (take) begin
          if (!crc_skip_first_byte) begin
            next_crc = crc_step;
          end
          next_state = !in_last_in ? RTC_DATA :
                       crc_enable ? RTC_CRC_LO : RTC_IDLE;
        end
      end
      RTC_DATA: begin
        if (take) begin
          next_crc = crc_step;
          if (in_last_in) begin
            next_state = crc_enable ? RTC_CRC_LO : RTC_IDLE;
          end
        end
      end
      RTC_CRC_LO: begin
        if (buf_ready) begin
          next_state = crc_five ? RTC_IDLE : RTC_CRC_HI;
        end
      end
      RTC_CRC_HI: begin
        if (buf_ready) begin
          next_state = RTC_IDLE;
        end
      end
      default: begin
        next_state = RTC_IDLE;
      end
    endcase
  end

  // Sequence and CRC register
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= RTC_IDLE;
      crc <= rtc_pkg::PRESET_0;
    end else begin
      state <= next_state;
      crc <= next_crc;
    end
  end

  // Buffer storage written at the write pointer
  always_ff @(posedge core_clk_in) begin
    if (push) begin
      buf_mem[buf_wr_ptr] <= {push_last, push_data};
    end
  end

  // Buffer pointers and fill count
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      buf_wr_ptr <= 1'b0;
      buf_rd_ptr <= 1'b0;
      buf_count <= 2'h0;
    end else begin
      if (push) begin
        buf_wr_ptr <= !buf_wr_ptr;
      end
      if (buf_pop) begin
        buf_rd_ptr <= !buf_rd_ptr;
      end
      buf_count <= buf_count + {1'b0, push} - {1'b0, buf_pop};
    end
  end

  // Encoder side; data leaves straight from the buffer flops
  assign out_valid_out = buf_count != 2'h0;
  assign out_data_out = out_valid_out ? buf_mem[buf_rd_ptr][7:0] : 8'h00;
  assign out_last_out = out_valid_out && buf_mem[buf_rd_ptr][8];
  // Busy until the last queued byte has left for the encoder
  assign tx_active_out = !st_idle || out_valid_out;

  // Status read returns the sequencer state and flags
  chk_status_read: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    rd_in && hit_status |=> rdata_out[2:0] == $past(seq_state_in) &&
      rdata_out[5] == $past(rx_enable_in) && rdata_out[3] == $past(rx_active_in))
    else $error("status read mismatch");

  chk_rx_enable_flag: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    rd_in && hit_status && rx_enable_in |=> rdata_out[5])
    else $error("receive enable flag lost");

  chk_tx_busy_flag: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    take && !in_last_in |=> tx_active_out [*2])
    else $error("transmit busy flag dropped during frame");

  // A last byte may leave one cycle later, so only the next cycle is owed
  chk_tx_busy_last: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    take && in_last_in |=> tx_active_out)
    else $error("transmit busy flag dropped at frame end");

  chk_rx_active_flag: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    rd_in && hit_status && !rx_active_in |=> !rdata_out[3])
    else $error("receive active flag set while idle");

  chk_cause_code: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    rd_in && hit_status |=> rdata_out[10:8] == $past(field_cause_in))
    else $error("field cause code mismatch");

  chk_preset_hold: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    st_idle && !take |=> crc == $past(init_val))
    else $error("idle register not at preset");

  chk_skip_first: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    st_idle && take && crc_skip_first_byte |=> crc == $past(init_val))
    else $error("first byte entered the checksum");

  chk_crc_tail: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    take && in_last_in |=> ($past(crc_enable) ? st_lo : st_idle))
    else $error("checksum tail not started as configured");

  chk_five_bit: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    tail_lo && crc_five |-> push_last && push_data[7:5] == 3'h0 ##1 st_idle)
    else $error("short checksum not a single last byte");

  chk_invert: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    tail_lo && !crc_five |-> push_data == (crc[7:0] ^ {8{crc_invert_out}}))
    else $error("checksum inversion wrong");

  chk_hi_last: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    st_hi && buf_ready |-> push_last ##1 st_idle)
    else $error("long checksum high byte not last");

  chk_crc_off_last: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    take && in_last_in && !crc_enable |-> push && push_last)
    else $error("frame without checksum not closed on its last byte");

  // Idle register against the preset chosen one cycle before
  chk_fixed_preset: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    st_idle && !take && !crc_five && preset_sel == 3'h1 |=> crc == rtc_pkg::PRESET_1)
    else $error("fixed preset not loaded");

  chk_custom_preset: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    st_idle && !take && !crc_five && preset_sel == rtc_pkg::SEL_CUSTOM |=>
      crc == $past(preset_custom))
    else $error("software preset not loaded");

  chk_short_preset: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    st_idle && !take && crc_five |=> crc[15:8] == 8'h00)
    else $error("short type used more than the low preset byte");

  // Transmitter settings follow a register write on the next cycle
  chk_level_write: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    wr_wave_cfg |=> drv1_level_modulated_out == $past(wdata_in[15:8]))
    else $error("modulated level not as written");

  chk_carrier_write: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    wr_wave_cfg |=> drv1_level_carrier_out == $past(wdata_in[7:0]))
    else $error("carrier level not as written");

  chk_clkmode_write: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    wr_wave_cfg |=> {drv1_clkmode_edge_out, drv1_clkmode_modulated_out,
      drv1_clkmode_carrier_out} == $past(wdata_in[24:16]))
    else $error("clock mode fields not as written");

endmodule : rtc_core

`default_nettype wire

// *** rtc_pkg.sv ***
// Constants for the contactless transmit CRC and status register slice.
// Shared by the slice top and its CRC byte engine; no other assumptions.

package rtc_pkg;

  // Register offsets as seen on the plain register port
  localparam logic [7:0] ADDR_STATUS = 8'h07;
  localparam logic [7:0] ADDR_CRC_CFG = 8'h12;
  localparam logic [7:0] ADDR_WAVE_CFG = 8'h16;

  // Status field positions
  localparam int ST_STATE_LSB = 0;
  localparam int ST_RX_ACTIVE = 3;
  localparam int ST_TX_ACTIVE = 4;
  localparam int ST_RX_ENABLE = 5;
  localparam int ST_CAUSE_LSB = 8;

  // CRC configuration field positions
  localparam int CC_ENABLE = 0;
  localparam int CC_INVERT = 1;
  localparam int CC_TYPE5 = 2;
  localparam int CC_SEL_LSB = 3;
  localparam int CC_SKIP = 6;
  localparam int CC_PRESET_LSB = 16;

  // Reset values and writable masks
  localparam logic [31:0] CRC_CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] CRC_CFG_MASK = 32'hFFFF_007F;
  localparam logic [31:0] WAVE_CFG_RESET = 32'h0000_00FF;
  localparam logic [31:0] WAVE_CFG_MASK = 32'h01FF_FFFF;

  // Wave configuration field positions
  localparam int WV_CARRIER_LSB = 0;
  localparam int WV_MOD_LSB = 8;
  localparam int WV_CLK_CW_LSB = 16;
  localparam int WV_CLK_MOD_LSB = 19;
  localparam int WV_CLK_EDGE_LSB = 22;

  // Preset selector codes and values
  localparam logic [2:0] SEL_CUSTOM = 3'h7;
  localparam logic [15:0] PRESET_0 = 16'h0000;
  localparam logic [15:0] PRESET_1 = 16'h6363;
  localparam logic [15:0] PRESET_2 = 16'hA671;
  localparam logic [15:0] PRESET_3 = 16'hFFFF;
  localparam logic [15:0] PRESET_4 = 16'h0012;
  localparam logic [15:0] PRESET_5 = 16'hE012;

  // Reflected polynomials, bits shifted in least significant first
  localparam logic [15:0] CRC16_POLY_REFL = 16'h8408;
  localparam logic [4:0] CRC5_POLY_REFL = 5'h12;

  // Buffer depth
  localparam logic [1:0] BUF_DEPTH = 2'h2;

endpackage : rtc_pkg

// *** rtc_crc_byte.sv ***
// One byte step of the transmit CRC, 16-bit or 5-bit.
// Purely combinational; the caller holds the CRC register.

`timescale 1ns/10ps
`default_nettype none

module rtc_crc_byte (
  // Current register and byte
  input wire logic [15:0] crc_in,
  input wire logic [7:0] data_in,
  input wire logic five_in,
  // Updated register
  output logic [15:0] crc_out
);

  // Bits enter least significant first, one shift per bit
  always_comb begin
    logic [15:0] c16;
    logic [4:0] c5;
    logic fb16;
    logic fb5;
    c16 = crc_in;
    c5 = crc_in[4:0];
    fb16 = 1'b0;
    fb5 = 1'b0;
    for (int i = 0; i < 8; i++) begin
      fb16 = c16[0] ^ data_in[i];
      c16 = {1'b0, c16[15:1]};
      if (fb16) begin
        c16 = c16 ^ rtc_pkg::CRC16_POLY_REFL;
      end
      fb5 = c5[0] ^ data_in[i];
      c5 = {1'b0, c5[4:1]};
      if (fb5) begin
        c5 = c5 ^ rtc_pkg::CRC5_POLY_REFL;
      end
    end
    // Short type updates only the low 5 bits; bits 15:5 pass through unchanged
    crc_out = five_in ? {crc_in[15:8], crc_in[7:5], c5} : c16;
  end

endmodule : rtc_crc_byte

`default_nettype wire

// *** rtc_tx_sink.sv ***
// Stand-in for the transmit encoder: takes bytes promptly, at random or not at all.
// Assumes the slice's byte output handshake runs on the same clock.
`timescale 1ns/10ps
`default_nettype none
module rtc_tx_sink (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Pace: 0 prompt, 1 random stall, 2 hold
  input wire logic [1:0] mode_in,
  // Handshake towards the slice
  output logic ready_out
);
  // Ready moves only after an edge; holding it shows whether the buffer loses bytes
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ready_out <= 1'h0;
    end else begin
      case (mode_in)
        2'h0: ready_out <= 1'h1;
        2'h1: ready_out <= 1'($urandom_range(1));
        default: ready_out <= 1'h0;
      endcase
    end
  end
endmodule : rtc_tx_sink
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the transmit CRC and status register slice.
// Assumes rtc_pkg, rtc_core and rtc_tx_sink are compiled first.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic [2:0] seq = 3'h0;
  logic rxen = 1'h0;
  logic rxact = 1'h0;
  logic [2:0] cause = 3'h0;
  logic iv = 1'h0;
  logic [7:0] idat = 8'h00;
  logic ilast = 1'h0;
  logic [1:0] mode = 2'h0;
  logic [31:0] rdata;
  logic irdy, ov, olast, ordy, txa;
  logic [7:0] odat, lc, lm;
  logic [2:0] cc, cm, ce;
  int errors = 0;
  int checked = 0;
  logic [31:0] rq[$];
  logic [8:0] bq[$];
  logic rd_seen = 1'h0;
  logic [15:0] presets[8] = '{16'h0000, 16'h6363, 16'hA671, 16'hFFFF,
                              16'h0012, 16'hE012, 16'h0000, 16'h0000};

  rtc_core dut_u (
    .core_clk_in(clk), .arst_n_in(arst_n), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .seq_state_in(seq),
    .rx_enable_in(rxen), .rx_active_in(rxact), .field_cause_in(cause),
    .in_valid_in(iv), .in_data_in(idat), .in_last_in(ilast), .in_ready_out(irdy),
    .out_valid_out(ov), .out_data_out(odat), .out_last_out(olast),
    .out_ready_in(ordy), .tx_active_out(txa), .drv1_level_carrier_out(lc),
    .drv1_level_modulated_out(lm), .drv1_clkmode_carrier_out(cc),
    .drv1_clkmode_modulated_out(cm), .drv1_clkmode_edge_out(ce)
  );
  rtc_tx_sink sink_u (.clk_in(clk), .arst_n_in(arst_n), .mode_in(mode), .ready_out(ordy));

  // 200 MHz
  always #2.5 clk = ~clk;

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  // Oldest note against each read answer and each byte taken by the encoder
  always @(posedge clk) begin
    if (rd_seen) check("rdata", rdata, rq.pop_front());
    if (ov === 1'h1 && ordy === 1'h1) begin
      check("byte", {olast, odat}, bq.pop_front());
      check("tx_active", txa, 1'h1);
    end
    rd_seen = rd;
  end

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
    @(posedge clk);
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
    addr <= a;
    rd <= 1'h1;
    rq.push_back(e);
    @(posedge clk);
    rd <= 1'h0;
    @(posedge clk);
  endtask : reg_rd

  // Valid and byte held until the edge that sees ready
  task automatic push_byte(input logic [7:0] d, input logic l);
    int n = 0;
    iv <= 1'h1;
    idat <= d;
    ilast <= l;
    do begin
      @(posedge clk);
      n++;
    end while (irdy !== 1'h1 && n < 200);
  endtask : push_byte

  // Reference CRC worked bit by bit, then the expected byte stream noted
  task automatic send_frame(input logic [31:0] c, input int len);
    logic [7:0] b[$];
    logic [15:0] r;
    logic fb;
    for (int i = 0; i < len; i++) b.push_back(8'($urandom));
    r = (c[5:3] == 3'h7) ? c[31:16] : presets[c[5:3]];
    if (c[2]) r = {11'h0, r[4:0]};
    for (int i = (c[6] ? 1 : 0); i < len; i++) begin
      for (int j = 0; j < 8; j++) begin
        fb = r[0] ^ b[i][j];
        r = c[2] ? ({12'h0, r[4:1]} ^ (fb ? 16'h0012 : 16'h0000))
                 : ((r >> 1) ^ (fb ? 16'h8408 : 16'h0000));
      end
    end
    if (c[1]) r = c[2] ? {11'h0, ~r[4:0]} : ~r;
    for (int i = 0; i < len; i++) bq.push_back({!c[0] && i == len - 1, b[i]});
    if (c[0] && c[2]) bq.push_back({4'h8, r[4:0]});
    if (c[0] && !c[2]) bq.push_back({1'h0, r[7:0]});
    if (c[0] && !c[2]) bq.push_back({1'h1, r[15:8]});
    for (int i = 0; i < len; i++) push_byte(b[i], i == len - 1);
    iv <= 1'h0;
  endtask : send_frame

  task automatic drain();
    int n = 0;
    while (bq.size() != 0 && n < 500) begin
      @(posedge clk);
      n++;
    end
    repeat (3) @(posedge clk);
    if (bq.size() != 0) check("drain", bq.size(), 0);
  endtask : drain

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    close_out();
  end

  // Main sequence
  initial begin
    logic [31:0] v;
    logic [31:0] st;
    void'($urandom(95));
    repeat (4) @(posedge clk);
    arst_n <= 1'h1;
    @(posedge clk);
    check("carrier_rst", lc, 8'hFF);
    reg_rd(rtc_pkg::ADDR_WAVE_CFG, 32'h0000_00FF);
    reg_rd(rtc_pkg::ADDR_CRC_CFG, 32'h0);
    // Every documented state code, cause codes 1 to 4, random decoder flags
    for (int i = 0; i < 7; i++) begin
      st = {21'h0, 3'(i % 4 + 1), 2'h0, 1'($urandom), 1'h0, 1'($urandom), 3'(i)};
      seq <= st[2:0];
      rxact <= st[3];
      rxen <= st[5];
      cause <= st[10:8];
      reg_rd(rtc_pkg::ADDR_STATUS, st);
    end
    reg_wr(rtc_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
    reg_rd(rtc_pkg::ADDR_STATUS, st);
    reg_rd(8'h20, 32'h0);
    v = $urandom;
    reg_wr(rtc_pkg::ADDR_WAVE_CFG, v);
    reg_rd(rtc_pkg::ADDR_WAVE_CFG, v & 32'h01FF_FFFF);
    check("drv1", {ce, cm, cc, lm, lc}, v[24:0]);
    v = $urandom;
    reg_wr(rtc_pkg::ADDR_CRC_CFG, v);
    reg_rd(rtc_pkg::ADDR_CRC_CFG, v & 32'hFFFF_007F);
    // Frames: all selectors, 5-bit, invert, skip, disabled, one-byte skip
    mode <= 2'h1;
    for (int k = 0; k < 12; k++) begin
      v = {16'($urandom), 9'h0, 1'(k == 3 || k >= 9), 3'(k < 8 ? k : (k == 8 ? 4 : 7)),
           1'(k == 8 || k == 9), 1'(k % 2), 1'(k != 10)};
      reg_wr(rtc_pkg::ADDR_CRC_CFG, v);
      send_frame(v, k == 11 ? 1 : 2 + k % 5);
      drain();
    end
    // Receiver holds: buffer fills and refuses, then drains with no loss
    mode <= 2'h2;
    reg_wr(rtc_pkg::ADDR_CRC_CFG, 32'h0);
    fork
      send_frame(32'h0, 5);
      begin
        repeat (12) @(posedge clk);
        check("in_ready_full", irdy, 1'h0);
        check("tx_active_full", txa, 1'h1);
        reg_rd(rtc_pkg::ADDR_STATUS, st | 32'h0000_0010);
        mode <= 2'h0;
      end
    join
    drain();
    reg_rd(rtc_pkg::ADDR_STATUS, st);
    repeat (2) @(posedge clk);
    close_out();
  end
endmodule : testbench
`default_nettype wire
